// *** hdl/scs_smbus_target.sv ***
// scs_smbus_target: two-wire configuration target holding the configuration registers.
// assumes scl/sda/chip select arrive asynchronously from pins and an external pull-up on sda.
// Summary of operation
// [R1] signalling and framing follow the two-wire management bus, version 2.0
// [R2] no dynamic address resolution; bus address comes from a register
// [R3] traffic is ignored and sda released while chip select is low
// [R4] host gives each device on a shared bus its own chip select
// [R5] data changes only while the clock is low
// [R6] sda falling while scl high is a start
// [R7] sda rising while scl high is a stop
// [R8] bus is idle after bus-free time past stop or after longest clock-high
// [R9] bytes are eight bits msb first plus a ninth acknowledge bit
// [R10] acknowledge bit low means ack, high means nack
// [R11] host opens a write with the seven-bit address and direction bit low
// [R12] first byte after address sets the pointer, next byte is stored
// [R13] each further write byte advances the pointer by one
// [R14] host ends every write with a stop
// [R15] read: address-write, pointer, repeated start, address-read
// [R16] after address-read the target returns the pointed register msb first
// [R17] host nack ends the read and the target releases sda
// [R18] soft reset restores defaults except the bus address register
// [R19] host ack during a read advances the pointer and returns the next register
`timescale 1ns/100ps

module scs_smbus_target #(
  parameter logic [15:0] THIGH_CYC = 16'(scs_pkg::THIGH_MAX_CYC)
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              bus_chip_select,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output      logic              sda_out,
  output      logic              sda_oe,
  output      logic              bus_idle,
  output      scs_pkg::scs_regs_t cfg_regs
);

  scs_pkg::scs_st_t q;
  scs_pkg::scs_st_t next_q;

  logic scl_s;
  logic sda_s;
  logic cs_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_hit;
  logic [7:0] rd_byte;
  logic [7:0] rd_next;

  // stage 0 of each pipe feeds stage 1 only; edges come from stages 1 and 2
  assign scl_s    = q.scl_p[1];
  assign sda_s    = q.sda_p[1];
  assign cs_s     = q.cs_p[1];
  assign scl_rise = scl_s & ~q.scl_p[2];
  assign scl_fall = ~scl_s & q.scl_p[2];
  assign start_ev = scl_s & q.scl_p[2] & ~sda_s & q.sda_p[2];  // see [R6]
  assign stop_ev  = scl_s & q.scl_p[2] & sda_s & ~q.sda_p[2];  // see [R7]
  // address is held in a register that the host can write, never resolved dynamically
  assign addr_hit = (q.sh[7:1] == q.regs[scs_pkg::ADDR_IDX][6:0]);  // see [R2] see [R1]
  assign rd_byte  = (q.ptr < scs_pkg::NREG_B) ? q.regs[q.ptr[3:0]] : 8'h00;
  assign rd_next  = ((q.ptr + 8'h01) < scs_pkg::NREG_B) ? q.regs[q.ptr[3:0] + 4'h1] : 8'h00;

  always_comb begin
    next_q = q;
    next_q.scl_p = {q.scl_p[1:0], scl_in};
    next_q.sda_p = {q.sda_p[1:0], sda_in};
    next_q.cs_p  = {q.cs_p[0], bus_chip_select};
    next_q.sda_o = 1'b0;

    // idle detection runs on the synchronised lines whether or not we are selected
    if (scl_s && sda_s) begin
      if (q.high_cnt != 16'hffff) begin
        next_q.high_cnt = q.high_cnt + 16'h0001;
      end
    end else begin
      next_q.high_cnt = 16'h0000;
    end
    next_q.bus_idle = (q.high_cnt >= THIGH_CYC) ||
                      (q.stopped && (q.high_cnt >= 16'(scs_pkg::TBUF_CYC)));  // see [R8]
    if (start_ev) begin
      next_q.stopped = 1'b0;
    end else if (stop_ev) begin
      next_q.stopped = 1'b1;
    end

    if (!cs_s) begin
      // deselected: sda released, any transfer in progress is dropped
      next_q.state  = scs_pkg::ST_IDLE;  // see [R3] see [R4]
      next_q.sda_oe = 1'b0;
    end else if (start_ev) begin
      // start and repeated start both restart address reception, pointer kept
      next_q.state  = scs_pkg::ST_ADDR;  // see [R6] see [R15]
      next_q.bitcnt = 4'h0;
      next_q.sda_oe = 1'b0;
    end else if (stop_ev) begin
      next_q.state  = scs_pkg::ST_IDLE;  // see [R7] see [R14]
      next_q.sda_oe = 1'b0;
    end else if (q.high_cnt >= THIGH_CYC && q.state != scs_pkg::ST_IDLE) begin
      next_q.state  = scs_pkg::ST_IDLE;  // see [R8]
      next_q.sda_oe = 1'b0;
    end else begin
      case (q.state)
        scs_pkg::ST_ADDR, scs_pkg::ST_RX: begin
          if (scl_rise && q.bitcnt != scs_pkg::BYTE_BITS) begin
            next_q.sh     = {q.sh[6:0], sda_s};  // see [R9]
            next_q.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == scs_pkg::BYTE_BITS) begin
            if (q.state == scs_pkg::ST_ADDR) begin
              if (addr_hit) begin
                next_q.rd     = q.sh[0];  // see [R11]
                next_q.first  = 1'b1;
                next_q.sda_oe = 1'b1;  // see [R10]
                next_q.state  = scs_pkg::ST_ACK;
              end else begin
                // not ours: stay off the bus until the next start
                next_q.state = scs_pkg::ST_IDLE;
              end
            end else begin
              next_q.sda_oe = 1'b1;  // see [R10]
              next_q.state  = scs_pkg::ST_ACK;
              next_q.first  = 1'b0;
              if (q.first) begin
                next_q.ptr = q.sh;  // see [R12]
              end else begin
                // bytes past the last register are acknowledged and dropped
                if (q.ptr < scs_pkg::NREG_B) begin
                  next_q.regs[q.ptr[3:0]] = q.sh;  // see [R12]
                end
                next_q.ptr = q.ptr + 8'h01;  // see [R13]
                if (q.ptr[3:0] == scs_pkg::SRST_IDX && q.ptr < scs_pkg::NREG_B && q.sh[scs_pkg::SRST_BIT]) begin
                  // soft reset keeps whatever bus address is in force
                  next_q.regs = scs_pkg::REG_RST;  // see [R18]
                  next_q.regs[scs_pkg::ADDR_IDX] = q.regs[scs_pkg::ADDR_IDX];
                end
              end
            end
          end
        end
        scs_pkg::ST_ACK: begin
          if (scl_fall) begin
            next_q.bitcnt = 4'h0;
            if (q.rd) begin
              // first read bit goes out on the same falling edge that ends the ack
              next_q.sh     = {rd_byte[6:0], 1'b0};  // see [R16]
              next_q.sda_oe = ~rd_byte[7];  // see [R5]
              next_q.bitcnt = 4'h1;
              next_q.state  = scs_pkg::ST_TX;
            end else begin
              next_q.sda_oe = 1'b0;
              next_q.state  = scs_pkg::ST_RX;
            end
          end
        end
        scs_pkg::ST_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == scs_pkg::BYTE_BITS) begin
              next_q.sda_oe = 1'b0;
              next_q.state  = scs_pkg::ST_HACK;
            end else begin
              next_q.sda_oe = ~q.sh[7];  // see [R16] see [R5]
              next_q.sh     = {q.sh[6:0], 1'b0};
              next_q.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        scs_pkg::ST_HACK: begin
          if (scl_rise) begin
            next_q.nack = sda_s;  // see [R10]
          end else if (scl_fall) begin
            if (q.nack) begin
              next_q.sda_oe = 1'b0;  // see [R17]
              next_q.state  = scs_pkg::ST_IDLE;
            end else begin
              next_q.ptr    = q.ptr + 8'h01;  // see [R19]
              next_q.sh     = {rd_next[6:0], 1'b0};
              next_q.sda_oe = ~rd_next[7];
              next_q.bitcnt = 4'h1;
              next_q.state  = scs_pkg::ST_TX;
            end
          end
        end
        default: begin
          next_q.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q          <= '0;
      q.scl_p    <= 3'b111;
      q.sda_p    <= 3'b111;
      q.state    <= scs_pkg::ST_IDLE;
      q.stopped  <= 1'b1;
      q.regs     <= scs_pkg::REG_RST;
    end else begin
      q <= next_q;
    end
  end

  assign sda_out  = q.sda_o;
  assign sda_oe   = q.sda_oe;
  assign bus_idle = q.bus_idle;
  assign cfg_regs = q.regs;

  property p_cs_release;
    @(posedge sys_clk) disable iff (!nrst) !cs_s |=> !q.sda_oe;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("sda driven while deselected");  // see [R3]

  property p_start;
    @(posedge sys_clk) disable iff (!nrst) (cs_s && start_ev) |=> (q.state == scs_pkg::ST_ADDR && q.bitcnt == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");  // see [R6]

  property p_stop;
    @(posedge sys_clk) disable iff (!nrst) stop_ev |=> (q.state == scs_pkg::ST_IDLE && !q.sda_oe);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");  // see [R7]

  property p_drive_on_fall;
    @(posedge sys_clk) disable iff (!nrst) $rose(q.sda_oe) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("sda driven while scl high");  // see [R5]

  property p_ack_low;
    @(posedge sys_clk) disable iff (!nrst) (q.state == scs_pkg::ST_ACK) |-> (q.sda_oe && !q.sda_o);
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack bit not driven low");  // see [R10]

  property p_bitcnt;
    @(posedge sys_clk) disable iff (!nrst) q.bitcnt <= scs_pkg::BYTE_BITS;
  endproperty
  a_bitcnt: assert property (p_bitcnt) else $error("bit count past eight");  // see [R9]

  property p_wr_inc;
    @(posedge sys_clk) disable iff (!nrst)
      (cs_s && q.state == scs_pkg::ST_RX && !q.first && scl_fall && q.bitcnt == scs_pkg::BYTE_BITS)
      |=> (q.ptr == $past(q.ptr) + 8'h01 && q.state == scs_pkg::ST_ACK);
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("write pointer not advanced");  // see [R13]

  property p_nack_end;
    @(posedge sys_clk) disable iff (!nrst)
      (cs_s && q.state == scs_pkg::ST_HACK && q.nack && scl_fall && !(q.high_cnt >= THIGH_CYC))
      |=> (q.state == scs_pkg::ST_IDLE && !q.sda_oe);
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("nack did not end read");  // see [R17]

  property p_rd_inc;
    @(posedge sys_clk) disable iff (!nrst)
      (cs_s && q.state == scs_pkg::ST_HACK && !q.nack && scl_fall && !(q.high_cnt >= THIGH_CYC))
      |=> (q.ptr == $past(q.ptr) + 8'h01 && q.state == scs_pkg::ST_TX);
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("read pointer not advanced");  // see [R19]

  property p_idle_tbuf;
    @(posedge sys_clk) disable iff (!nrst)
      (q.stopped && q.high_cnt >= 16'(scs_pkg::TBUF_CYC)) |=> q.bus_idle;
  endproperty
  a_idle_tbuf: assert property (p_idle_tbuf) else $error("bus not idle after free time");  // see [R8]

  property p_thigh_idle;
    @(posedge sys_clk) disable iff (!nrst)
      (cs_s && q.state != scs_pkg::ST_IDLE && q.high_cnt >= THIGH_CYC && !start_ev && !stop_ev)
      |=> (q.state == scs_pkg::ST_IDLE && !q.sda_oe);
  endproperty
  a_thigh_idle: assert property (p_thigh_idle) else $error("clock-high limit did not end transfer");  // see [R8]

endmodule // scs_smbus_target

// *** include/scs_pkg.sv ***
// scs_pkg: constants, state enum and state record of the configuration-bus target.
// assumes a single 100 MHz system clock that oversamples the two-wire bus.
package scs_pkg;

  localparam int          CLK_NS        = 10;
  // bus-free time after a stop, least value
  localparam int          TBUF_NS       = 4700;
  localparam int          TBUF_CYC      = (TBUF_NS + CLK_NS - 1) / CLK_NS;
  // longest clock-high time before the bus counts as idle
  localparam int          THIGH_MAX_NS  = 50000;
  localparam int          THIGH_MAX_CYC = THIGH_MAX_NS / CLK_NS;

  localparam int          NREG          = 16;
  localparam int          IDX_W         = 4;
  localparam logic [3:0]  ADDR_IDX      = 4'h0;
  localparam logic [3:0]  SRST_IDX      = 4'h1;
  localparam int          SRST_BIT      = 0;
  // default bus address, arbitrary
  localparam logic [6:0]  DEF_DEV_ADDR  = 7'h2d;
  localparam logic [7:0]  NREG_B        = 8'h10;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  typedef logic [NREG-1:0][7:0] scs_regs_t;
  localparam scs_regs_t   REG_RST       = {{(NREG-1){8'h00}}, {1'b0, DEF_DEV_ADDR}};

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_HACK
  } scs_state_t;

  typedef struct packed {
    logic [2:0]  scl_p;
    logic [2:0]  sda_p;
    logic [1:0]  cs_p;
    scs_state_t  state;
    logic [7:0]  sh;
    logic [3:0]  bitcnt;
    logic        rd;
    logic        first;
    logic        nack;
    logic [7:0]  ptr;
    logic        sda_oe;
    logic        sda_o;
    logic        stopped;
    logic        bus_idle;
    logic [15:0] high_cnt;
    scs_regs_t   regs;
  } scs_st_t;

endpackage

// *** verification/scs_host_model.sv ***
// scs_host_model: behavioural two-wire bus master for the configuration target.
// assumes the bench pulls sda up and resolves the wired-AND; scl rests high between frames.
`timescale 1ns/100ps

module scs_host_model (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output      logic scl,
  output      logic sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // data moves mid-low, sampled mid-high, so setup is met at both ends
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_low = !b;
    wt(2);
    scl = 1'b1;
    wt(2);
    r = sda_line;
    wt(2);
    scl = 1'b0;
  endtask

  // both lines parked high for n cycles; scl dropped afterwards when asked
  task automatic hold_high(input int n, input logic drop);
    wt(2);
    sda_low = 1'b0;
    wt(2);
    scl = 1'b1;
    wt(n);
    if (drop) begin
      scl = 1'b0;
    end
  endtask

  task automatic start();
    wt(2);
    sda_low = 1'b0;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    wt(2);
    sda_low = 1'b1;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b0;
    wt(4);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask

  // last byte is answered with a high ninth bit
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule // scs_host_model

// *** verification/tb_scs_smbus_target.sv ***
// tb_scs_smbus_target: self-checking bench of the configuration-bus target.
// assumes scs_host_model as bus master and a pull-up on sda modelled here.
`timescale 1ns/100ps

module tb_scs_smbus_target;
  logic               sys_clk = 1'b0;
  logic               nrst;
  logic               bus_chip_select;
  logic               sda_out;
  logic               sda_oe;
  logic               bus_idle;
  logic               scl;
  logic               sda_low;
  logic               sda_line;
  logic               ack;
  logic [7:0]         rd;
  scs_pkg::scs_regs_t cfg_regs;
  int                 miscompares;
  int                 checks;
  int                 cycles;

  assign sda_line = !(sda_low || (sda_oe && !sda_out));

  // clock-high limit above the bus-free time so the two idle paths can be told apart
  scs_smbus_target #(.THIGH_CYC(16'h0258)) i_scs_smbus_target (
    .sys_clk(sys_clk), .nrst(nrst), .bus_chip_select(bus_chip_select), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .bus_idle(bus_idle), .cfg_regs(cfg_regs));
  scs_host_model i_scs_host_model (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    i_scs_host_model.send_byte(d, ack);
    check("ack", {7'h00, ack}, {7'h00, exp_ack});
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    i_scs_host_model.start();
    check("idle_at_start", {7'h00, bus_idle}, 8'h00);
    send({dev, 1'b0}, 1'b0);
    send(p, 1'b0);
    send(d0, 1'b0);
    send(d1, 1'b0);
    i_scs_host_model.stop();
  endtask

  task automatic t_reset();
    for (int i = 0; i < 16; i++) begin
      check("reg_rst", cfg_regs[i], scs_pkg::REG_RST[i]);
    end
    i_scs_host_model.wt(480);
    check("idle_after_rst", {7'h00, bus_idle}, 8'h01);
  endtask

  // idle must come only once the free time after the stop has run out
  task automatic t_write();
    wr(7'h2d, 8'h02, 8'ha5, 8'h3c);
    check("idle_after_stop", {7'h00, bus_idle}, 8'h00);
    i_scs_host_model.wt(460);
    check("idle_early", {7'h00, bus_idle}, 8'h00);
    i_scs_host_model.wt(20);
    check("idle_tbuf", {7'h00, bus_idle}, 8'h01);
    check("reg2", cfg_regs[2], 8'ha5);
    check("reg3", cfg_regs[3], 8'h3c);
  endtask

  task automatic t_read();
    i_scs_host_model.start();
    send(8'h5a, 1'b0);
    send(8'h02, 1'b0);
    i_scs_host_model.start();
    send(8'h5b, 1'b0);
    i_scs_host_model.recv_byte(1'b0, rd);
    check("rd0", rd, 8'ha5);
    i_scs_host_model.recv_byte(1'b1, rd);
    check("rd1", rd, 8'h3c);
    i_scs_host_model.wt(4);
    check("released", {7'h00, sda_oe}, 8'h00);
    check("sda_out", {7'h00, sda_out}, 8'h00);
    i_scs_host_model.stop();
  endtask

  // foreign address, then chip select low: both must leave the bus alone
  task automatic t_refuse();
    i_scs_host_model.start();
    send(8'h58, 1'b1);
    i_scs_host_model.stop();
    bus_chip_select = 1'b0;
    i_scs_host_model.start();
    send(8'h5a, 1'b1);
    send(8'h02, 1'b1);
    send(8'hff, 1'b1);
    i_scs_host_model.stop();
    @(negedge sys_clk) bus_chip_select = 1'b1;
    check("reg2_kept", cfg_regs[2], 8'ha5);
  endtask

  // a frame left hanging with both lines high ends on the clock-high limit, not the free time
  task automatic t_timeout();
    i_scs_host_model.start();
    send(8'h5a, 1'b0);
    i_scs_host_model.hold_high(476, 1'b0);
    check("idle_no_stop", {7'h00, bus_idle}, 8'h00);
    i_scs_host_model.hold_high(136, 1'b1);
    check("idle_thigh", {7'h00, bus_idle}, 8'h01);
    i_scs_host_model.stop();
  endtask

  task automatic t_srst();
    wr(7'h2d, 8'h00, 8'h2e, 8'h01);
    check("addr_kept", cfg_regs[0], 8'h2e);
    check("reg1_def", cfg_regs[1], 8'h00);
    check("reg2_def", cfg_regs[2], 8'h00);
    check("reg3_def", cfg_regs[3], 8'h00);
    wr(7'h2e, 8'h04, 8'h11, 8'h22);
    check("reg5_new", cfg_regs[5], 8'h22);
  endtask

  initial begin
    nrst = 1'b0;
    bus_chip_select = 1'b1;
    miscompares = 0;
    checks = 0;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_refuse();
    t_timeout();
    t_srst();
    complete_run();
  end
endmodule // tb_scs_smbus_target
